// [src/rps_pkg.sv]
// Constants and types shared by the remappable pin select design
package rps_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_PINS     = 26;
  localparam int NUM_IN_REGS  = 20;
  localparam int NUM_OUT_REGS = 13;
  localparam int NUM_FN       = 31;
  localparam int NUM_AN       = 9;
  localparam int SEL_W        = 5;
  localparam int DATA_W       = 32;
  localparam int ADDR_W       = 8;

  // ==========================================================================
  // Register word addresses
  localparam logic [ADDR_W-1:0] IN_REMAP_BASE  = 8'h00;
  localparam logic [ADDR_W-1:0] OUT_REMAP_BASE = 8'h14;
  localparam logic [ADDR_W-1:0] AN_CFG_A_ADDR  = 8'h21;
  localparam logic [ADDR_W-1:0] AN_CFG_B_ADDR  = 8'h22;
  localparam logic [ADDR_W-1:0] DIR_ADDR       = 8'h23;
  localparam logic [ADDR_W-1:0] LATCH_ADDR     = 8'h24;
  localparam logic [ADDR_W-1:0] PORT_ADDR      = 8'h25;
  localparam logic [ADDR_W-1:0] PULLUP_ADDR    = 8'h26;
  localparam logic [ADDR_W-1:0] LOCK_ADDR      = 8'h27;

  // ==========================================================================
  // Field positions and codes
  localparam int SEL_HI_LSB = 8;
  localparam int SEL_LO_LSB = 0;
  localparam int LOCK_BIT   = 0;
  localparam logic [SEL_W-1:0] SEL_GROUND  = 5'h1F;
  localparam logic [SEL_W-1:0] SEL_MAX_PIN = 5'h19;
  localparam logic [SEL_W-1:0] FN_PORT     = 5'h00;

  // ==========================================================================
  // Values after reset and write masks
  localparam logic [15:0] IN_REMAP_RST   = 16'h1F00;
  localparam logic [15:0] IN_REMAP_MASK  = 16'h1F00;
  localparam logic [15:0] OUT_REMAP_RST  = 16'h0000;
  localparam logic [15:0] OUT_REMAP_MASK = 16'h1F1F;
  localparam logic [NUM_AN-1:0]   AN_CFG_RST = 9'h000;
  localparam logic [NUM_PINS-1:0] DIR_RST    = 26'h3FF_FFFF;
  localparam logic [NUM_PINS-1:0] PIN_ZERO   = 26'h000_0000;

  typedef logic [SEL_W-1:0] rps_sel_t;

endpackage

// [src/rps_sel_if.sv]
// Carrier between the register core and the input remap selector
`timescale 1ns/1ps
`default_nettype none
interface rps_sel_if;
  import rps_pkg::*;
  logic     [NUM_PINS-1:0]    pin_digital;
  rps_sel_t                   sel [NUM_IN_REGS];
  logic     [NUM_IN_REGS-1:0] periph_in;

  modport mux (input pin_digital, input sel, output periph_in);
  modport ctl (output pin_digital, output sel, input periph_in);
endinterface
`default_nettype wire

// [src/rps_input_mux.sv]
// Selects the pin that feeds each remappable peripheral input
`timescale 1ns/1ps
`default_nettype none
module rps_input_mux
  import rps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Selector link
  rps_sel_if.mux   sif
);

  // ==========================================================================
  // One registered selector per peripheral input
  logic [NUM_IN_REGS-1:0] periph_reg;
  logic [NUM_IN_REGS-1:0] periph_next;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN_REGS; gi++)
    begin : g_sel
      // Codes 26..30 have no pin behind them and read as ground too
      assign periph_next[gi] = (sif.sel[gi] <= SEL_MAX_PIN)
                             ? sif.pin_digital[sif.sel[gi]]
                             : 1'b0;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      periph_reg <= '0;
    else
      periph_reg <= periph_next;
  end

  assign sif.periph_in = periph_reg;

  // ==========================================================================
  // Checks
  pin_route_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    sif.sel[1] <= SEL_MAX_PIN
    |=> sif.periph_in[1] == $past(sif.pin_digital[sif.sel[1]]))
    else $error("peripheral input 1 not routed from selected pin");

  ground_tie_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    sif.sel[0] == SEL_GROUND |=> !sif.periph_in[0])
    else $error("ground code did not tie input low");

endmodule // rps_input_mux
`default_nettype wire

// [src/rps_pin_select.sv]
// Remappable pin select: remap registers, analog sharing and pin drive
//
// Functional notes
// - After any reset every analog-shared pin starts in analog mode.
// - Analog pin has digital input off; digital read returns 0.
// - Writing 1 to a pin's analog config bit makes it digital.
// - Pin shared by two converters is digital only if both bits say so.
// - Output driver follows direction bit even while analog mode is on.
// - Function picked by the pin's output remap code owns the pin over the port latch.
// - Each change-notify pin has a software-switched weak pull-up.
// - Twenty input remap registers and thirteen output remap registers.
// - External interrupt 1 select is bits 12..8, resets to all ones.
// - Input select code equals remappable pin number, 0 through 25.
// - Input select code 11111 ties the peripheral input to ground.
`timescale 1ns/1ps
`default_nettype none
module rps_pin_select
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [DATA_W-1:0]      reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [DATA_W-1:0]      reg_rdata,
  // Pins
  input  wire logic [NUM_PINS-1:0]    pin_in,
  output logic      [NUM_PINS-1:0]    pin_out,
  output logic      [NUM_PINS-1:0]    pin_oe,
  output logic      [NUM_PINS-1:0]    pin_pullup_en,
  // Peripherals
  input  wire logic [NUM_FN-1:0]      periph_fn_out,
  output logic      [NUM_IN_REGS-1:0] periph_in,
  output logic      [NUM_AN-1:0]      analog_mode
);

  // ==========================================================================
  // Address decoding
  function automatic logic in_window(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base,
                                     input int                n);
    in_window = (a >= base) && (int'(a - base) < n);
  endfunction

  logic                  hit_in;
  logic                  hit_out;
  logic [4:0]            in_idx;
  logic [3:0]            out_idx;
  logic                  lock_reg;
  logic                  remap_open;
  logic                  wr_in;
  logic                  wr_out;

  assign hit_in     = in_window(reg_addr, IN_REMAP_BASE, NUM_IN_REGS);
  assign hit_out    = in_window(reg_addr, OUT_REMAP_BASE, NUM_OUT_REGS);
  assign in_idx     = 5'(reg_addr - IN_REMAP_BASE);
  assign out_idx    = 4'(reg_addr - OUT_REMAP_BASE);
  assign remap_open = !lock_reg;
  assign wr_in      = reg_wr && hit_in && remap_open;
  assign wr_out     = reg_wr && hit_out && remap_open;

  // ==========================================================================
  // Remap registers
  logic [15:0] in_remap_reg  [NUM_IN_REGS];
  logic [15:0] out_remap_reg [NUM_OUT_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN_REGS; gi++)
    begin : g_in
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          in_remap_reg[gi] <= IN_REMAP_RST;
        else if (wr_in && in_idx == 5'(gi))
          in_remap_reg[gi] <= reg_wdata[15:0] & IN_REMAP_MASK;
      end
    end
    for (gi = 0; gi < NUM_OUT_REGS; gi++)
    begin : g_out
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          out_remap_reg[gi] <= OUT_REMAP_RST;
        else if (wr_out && out_idx == 4'(gi))
          out_remap_reg[gi] <= reg_wdata[15:0] & OUT_REMAP_MASK;
      end
    end
  endgenerate

  // ==========================================================================
  // Pin control registers
  logic [NUM_AN-1:0]   an_cfg_a_reg;
  logic [NUM_AN-1:0]   an_cfg_b_reg;
  logic [NUM_PINS-1:0] dir_reg;
  logic [NUM_PINS-1:0] latch_reg;
  logic [NUM_PINS-1:0] pullup_reg;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      an_cfg_a_reg <= AN_CFG_RST;
      an_cfg_b_reg <= AN_CFG_RST;
      dir_reg      <= DIR_RST;
      latch_reg    <= PIN_ZERO;
      pullup_reg   <= PIN_ZERO;
      lock_reg     <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == AN_CFG_A_ADDR)
        an_cfg_a_reg <= reg_wdata[NUM_AN-1:0];
      if (reg_addr == AN_CFG_B_ADDR)
        an_cfg_b_reg <= reg_wdata[NUM_AN-1:0];
      if (reg_addr == DIR_ADDR)
        dir_reg <= reg_wdata[NUM_PINS-1:0];
      if (reg_addr == LATCH_ADDR)
        latch_reg <= reg_wdata[NUM_PINS-1:0];
      if (reg_addr == PULLUP_ADDR)
        pullup_reg <= reg_wdata[NUM_PINS-1:0];
      if (reg_addr == LOCK_ADDR)
        lock_reg <= reg_wdata[LOCK_BIT];
    end
  end

  // ==========================================================================
  // Analog sharing and digital input path
  logic [NUM_PINS-1:0] digital_en;
  logic [NUM_PINS-1:0] pin_digital;

  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_dig
      if (gi < NUM_AN)
      begin : g_an
        // Both converters must release the pin before it turns digital
        assign digital_en[gi] = an_cfg_a_reg[gi] & an_cfg_b_reg[gi];
      end
      else
      begin : g_io
        assign digital_en[gi] = 1'b1;
      end
    end
  endgenerate

  // Analog owns the input side first, so a disabled buffer reads as 0
  assign pin_digital = pin_in & digital_en;

  // ==========================================================================
  // Output drive: remapped function outranks the port latch
  logic [NUM_PINS-1:0] pin_out_next;
  logic [NUM_PINS-1:0] pin_oe_next;
  rps_sel_t            fn_code [NUM_PINS];

  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_drv
      assign fn_code[gi] = (gi % 2 == 0)
        ? out_remap_reg[gi/2][SEL_LO_LSB +: SEL_W]
        : out_remap_reg[gi/2][SEL_HI_LSB +: SEL_W];
      assign pin_out_next[gi] = (fn_code[gi] == FN_PORT)
        ? latch_reg[gi]
        : periph_fn_out[5'(fn_code[gi] - 5'h01)];
    end
  endgenerate

  // Driver is not gated by analog mode; contention is the user's risk
  assign pin_oe_next = ~dir_reg;

  // ==========================================================================
  // Input selector
  rps_sel_if sif ();

  assign sif.pin_digital = pin_digital;
  generate
    for (gi = 0; gi < NUM_IN_REGS; gi++)
    begin : g_sel
      assign sif.sel[gi] = in_remap_reg[gi][SEL_HI_LSB +: SEL_W];
    end
  endgenerate

  rps_input_mux u_input_mux (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .sif      (sif)
  );

  assign periph_in = sif.periph_in;

  // ==========================================================================
  // Read path
  logic [DATA_W-1:0] rdata_next;

  always_comb
  begin
    rdata_next = '0;
    if (reg_rd)
    begin
      if (hit_in)
        rdata_next = {16'h0000, in_remap_reg[in_idx]};
      else if (hit_out)
        rdata_next = {16'h0000, out_remap_reg[out_idx]};
      else
        case (reg_addr)
          AN_CFG_A_ADDR: rdata_next = DATA_W'(an_cfg_a_reg);
          AN_CFG_B_ADDR: rdata_next = DATA_W'(an_cfg_b_reg);
          DIR_ADDR:      rdata_next = DATA_W'(dir_reg);
          LATCH_ADDR:    rdata_next = DATA_W'(latch_reg);
          PORT_ADDR:     rdata_next = DATA_W'(pin_digital);
          PULLUP_ADDR:   rdata_next = DATA_W'(pullup_reg);
          LOCK_ADDR:     rdata_next = DATA_W'(lock_reg);
          default:       rdata_next = '0;
        endcase
    end
  end

  // ==========================================================================
  // Output flops
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata     <= '0;
      pin_out       <= PIN_ZERO;
      pin_oe        <= PIN_ZERO;
      pin_pullup_en <= PIN_ZERO;
      analog_mode   <= '1;
    end
    else
    begin
      reg_rdata     <= rdata_next;
      pin_out       <= pin_out_next;
      pin_oe        <= pin_oe_next;
      pin_pullup_en <= pullup_reg;
      analog_mode   <= ~digital_en[NUM_AN-1:0];
    end
  end

  // ==========================================================================
  // Checks
  reset_analog_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    $past(!rst_b) |-> (an_cfg_a_reg == '0) && (an_cfg_b_reg == '0))
    else $error("analog config not cleared after reset");

  analog_read_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == PORT_ADDR && !digital_en[0] |=> !reg_rdata[0])
    else $error("analog pin read back nonzero");

  dual_conv_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    sif.sel[2] == 5'h03 && !an_cfg_b_reg[3] |=> !periph_in[2])
    else $error("pin passed digital with one converter analog");

  digital_enable_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    reg_wr && reg_addr == AN_CFG_A_ADDR && reg_wdata[1] && an_cfg_b_reg[1]
    && !(reg_wr && reg_addr == AN_CFG_B_ADDR)
    |=> ##1 !analog_mode[1])
    else $error("pin stayed analog after digital config");

  analog_drive_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    !dir_reg[0] && !digital_en[0] |=> pin_oe[0])
    else $error("driver off in analog mode with output direction");

  fn_priority_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    fn_code[4] != FN_PORT
    |=> pin_out[4] == $past(periph_fn_out[5'(fn_code[4] - 5'h01)]))
    else $error("remapped function did not own the pin");

  pullup_ctrl_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    reg_wr && reg_addr == PULLUP_ADDR
    |-> ##2 pin_pullup_en == $past(reg_wdata[NUM_PINS-1:0], 2))
    else $error("pull-up enable did not follow write");

  last_input_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    wr_in && reg_addr == 8'h13
    |=> in_remap_reg[19] == ($past(reg_wdata[15:0]) & IN_REMAP_MASK))
    else $error("twentieth input remap register not written");

  int1_reset_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    $past(!rst_b) |-> sif.sel[0] == SEL_GROUND)
    else $error("interrupt 1 select not all ones after reset");

  locked_write_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    lock_reg && reg_wr && reg_addr == IN_REMAP_BASE
    |=> $stable(in_remap_reg[0]))
    else $error("remap register changed while locked");

  // An open write must land, else the locked check above proves nothing
  open_write_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    !lock_reg && reg_wr && reg_addr == IN_REMAP_BASE
    |=> in_remap_reg[0] == ($past(reg_wdata[15:0]) & IN_REMAP_MASK))
    else $error("unlocked remap write did not land");

  latch_drive_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    fn_code[0] == FN_PORT |=> pin_out[0] == $past(latch_reg[0]))
    else $error("port latch did not drive unmapped pin");

endmodule // rps_pin_select
`default_nettype wire

// [sim/rps_pin_select_tb_top.sv]
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ps
`default_nettype none
module rps_pin_select_tb_top
  import rps_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals
  logic                   core_clk;
  logic                   rst_b;
  logic [ADDR_W-1:0]      reg_addr;
  logic [DATA_W-1:0]      reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [DATA_W-1:0]      reg_rdata;
  logic [NUM_PINS-1:0]    pin_in;
  logic [NUM_PINS-1:0]    pin_out;
  logic [NUM_PINS-1:0]    pin_oe;
  logic [NUM_PINS-1:0]    pin_pullup_en;
  logic [NUM_FN-1:0]      periph_fn_out;
  logic [NUM_IN_REGS-1:0] periph_in;
  logic [NUM_AN-1:0]      analog_mode;
  logic [DATA_W-1:0]      exp_q [$];
  logic                   rd_d1;
  int                     failures;
  int                     num_checks;
  int                     cycles;

  rps_pin_select u_rps_pin_select (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .pin_in        (pin_in),
    .pin_out       (pin_out),
    .pin_oe        (pin_oe),
    .pin_pullup_en (pin_pullup_en),
    .periph_fn_out (periph_fn_out),
    .periph_in     (periph_in),
    .analog_mode   (analog_mode)
  );

  always #10 core_clk = ~core_clk;

  // ==========================================================================
  // Comparison and bus tasks
  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Strobe stays up until the next call or settle, so transfers can abut
  task automatic bus(input logic is_wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr    <= is_wr;
    reg_rd    <= ~is_wr;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Drop strobes, let n more edges pass, then sample at the falling edge
  task automatic settle(input int n);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ==========================================================================
  // Read-data watcher: pops the oldest note when read data is due
  always @(posedge core_clk)
  begin
    rd_d1 <= reg_rd;
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  always @(negedge core_clk)
  begin
    if (rst_b && rd_d1)
    begin
      if (exp_q.size() == 0)
        failures++;
      else
        check(reg_rdata, exp_q.pop_front());
    end
    else if (rst_b)
      check(reg_rdata, 32'h0000_0000);
  end

  // ==========================================================================
  // Main sequence
  initial
  begin : main
    logic [DATA_W-1:0]   w;
    logic [NUM_PINS-1:0] latch_v;
    logic [NUM_AN-1:0]   a;
    logic [NUM_AN-1:0]   b;
    logic [NUM_AN-1:0]   ab;
    logic [SEL_W-1:0]    code [NUM_PINS];
    logic [DATA_W-1:0]   out0;
    logic                e;
    int                  i;
    void'($urandom(89269));
    core_clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d1 = 1'b0;
    pin_in = '0;
    periph_fn_out = '0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check(32'(analog_mode), 32'h0000_01FF);
    check(32'(periph_in), 32'h0000_0000);
    check(32'(pin_oe), 32'h0000_0000);
    for (int k = 0; k < NUM_IN_REGS; k++)
      rd(IN_REMAP_BASE + 8'(k), 32'(IN_REMAP_RST));
    for (int k = 0; k < NUM_OUT_REGS; k++)
      rd(OUT_REMAP_BASE + 8'(k), 32'h0000_0000);
    rd(AN_CFG_A_ADDR, 32'h0000_0000);
    rd(AN_CFG_B_ADDR, 32'h0000_0000);
    rd(DIR_ADDR, 32'(DIR_RST));
    rd(PULLUP_ADDR, 32'h0000_0000);
    rd(8'h28, 32'h0000_0000);
    wr(8'h28, 32'hFFFF_FFFF);
    rd(8'h28, 32'h0000_0000);
    settle(1);
    // Output drive keeps working on analog pins
    latch_v = NUM_PINS'($urandom);
    wr(DIR_ADDR, 32'h0000_0000);
    wr(LATCH_ADDR, 32'(latch_v));
    settle(1);
    check(32'(pin_oe), 32'h03FF_FFFF);
    check(32'(pin_out), 32'(latch_v));
    check(32'(analog_mode), 32'h0000_01FF);
    // Output remap: peripheral function owns the pin over the latch
    @(posedge core_clk);
    periph_fn_out <= NUM_FN'($urandom);
    for (int k = 0; k < NUM_OUT_REGS; k++)
    begin
      w = $urandom;
      code[2*k] = w[4:0];
      code[2*k+1] = w[12:8];
      if (k == 0)
        out0 = w & 32'(OUT_REMAP_MASK);
      wr(OUT_REMAP_BASE + 8'(k), w);
      rd(OUT_REMAP_BASE + 8'(k), w & 32'(OUT_REMAP_MASK));
    end
    settle(1);
    for (int p = 0; p < NUM_PINS; p++)
    begin
      e = (code[p] == FN_PORT) ? latch_v[p] : periph_fn_out[code[p] - 1];
      check(32'(pin_out[p]), 32'(e));
    end
    // Every input code, analog pins read as 0
    for (int p = 0; p < 32; p++)
    begin
      // Index walk puts codes 0, 2 and 3 into registers 19, 1 and 2
      i = (p + 19) % NUM_IN_REGS;
      w = $urandom;
      w[12:8] = 5'(p);
      wr(IN_REMAP_BASE + 8'(i), w);
      pin_in <= NUM_PINS'($urandom);
      rd(IN_REMAP_BASE + 8'(i), w & 32'(IN_REMAP_MASK));
      settle(1);
      e = (p >= NUM_AN && p <= 25) ? pin_in[p] : 1'b0;
      check(32'(periph_in[i]), 32'(e));
    end
    // Digital only when both converter configs set the bit
    for (int j = 0; j < 6; j++)
    begin
      a = (j == 0 || j == 5) ? 9'h1FF : NUM_AN'($urandom);
      b = (j == 0) ? 9'h000 : (j == 5) ? 9'h1FF : NUM_AN'($urandom);
      ab = a & b;
      wr(AN_CFG_A_ADDR, 32'(a));
      wr(AN_CFG_B_ADDR, 32'(b));
      settle(1);
      check(32'(analog_mode), {23'h00_0000, ~ab});
      rd(PORT_ADDR, 32'(pin_in & {17'h1_FFFF, ab}));
    end
    wr(IN_REMAP_BASE, 32'h0000_0400);
    settle(1);
    check(32'(periph_in[0]), 32'(pin_in[4]));
    // Pull-ups
    w = 32'(NUM_PINS'($urandom));
    wr(PULLUP_ADDR, w);
    rd(PULLUP_ADDR, w);
    settle(1);
    check(32'(pin_pullup_en), w);
    // Lock blocks remap writes only
    wr(LOCK_ADDR, 32'h0000_0001);
    rd(LOCK_ADDR, 32'h0000_0001);
    wr(IN_REMAP_BASE, 32'h0000_0700);
    wr(OUT_REMAP_BASE, 32'h0000_0101);
    wr(LATCH_ADDR, 32'h0000_0000);
    rd(IN_REMAP_BASE, 32'h0000_0400);
    rd(OUT_REMAP_BASE, out0);
    rd(LATCH_ADDR, 32'h0000_0000);
    wr(LOCK_ADDR, 32'h0000_0000);
    wr(IN_REMAP_BASE, 32'h0000_0700);
    rd(IN_REMAP_BASE, 32'h0000_0700);
    settle(3);
    if (exp_q.size() != 0)
      failures++;
    tally_and_finish();
  end
endmodule // rps_pin_select_tb_top
`default_nettype wire
